// ==== rtl/pmoc_pkg.sv ====
// Constants, tables and carrier types for the output configuration command bank.
// Assumes one 20 MHz clock and a command decoder outside that presents whole bytes.
package pmoc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int US_NS = 1000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;
  localparam int BLANK_US = 100;
  localparam int BLANK_CYC = BLANK_US * US_CYC;

  // ----------------------------------------------------------------------
  // Command codes and paging
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_FREQ_PHASE = 8'hd7;
  localparam logic [7:0] CMD_REF_SETPOINT = 8'hd8;
  localparam logic [7:0] CMD_CUR_LIMIT = 8'hd9;
  localparam logic [7:0] CMD_NOTIFY_FLAG = 8'hda;
  localparam logic [7:0] CMD_SW_RST = 8'hdb;
  localparam logic [7:0] CMD_HOLD_TIME = 8'hdc;
  localparam logic [7:0] CMD_WAIT_TIMES = 8'hdd;
  localparam logic [7:0] PAGE_MAX = 8'h03;
  localparam int NUM_OUT = 4;

  // ----------------------------------------------------------------------
  // Field positions and values after reset
  // ----------------------------------------------------------------------
  localparam int REF_MSB = 6;
  localparam int ILIM_WIDE_MSB = 2;
  localparam int ILIM_NARROW_MSB = 1;
  localparam int ON_WAIT_LSB = 3;
  localparam int OFF_WAIT_LSB = 0;
  localparam int NOTIFY_BIT = 0;
  localparam logic [6:0] REF_RST = 7'h14;
  localparam logic [2:0] ILIM_WIDE_RST = 3'h4;
  localparam logic [2:0] ILIM_NARROW_RST = 3'h3;
  localparam logic [5:0] WAITS_RST = 6'h10;
  localparam logic [2:0] HOLD_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Code tables, index 0 at the right
  // ----------------------------------------------------------------------
  localparam logic [7:0][11:0] HOLD_MS = {12'd2000, 12'd1500, 12'd1000, 12'd500,
                                          12'd250, 12'd100, 12'd50, 12'd1};
  localparam logic [7:0][11:0] WAIT_MS = {12'd2000, 12'd1000, 12'd500, 12'd100,
                                          12'd25, 12'd5, 12'd1, 12'd0};
  localparam logic [7:0][4:0] TSTEP_US = {5'd16, 5'd12, 5'd8, 5'd6, 5'd4, 5'd3, 5'd2, 5'd1};
  localparam logic [7:0][4:0] BSTEP_UP = {5'd16, 5'd12, 5'd10, 5'd8, 5'd6, 5'd4, 5'd2, 5'd1};
  localparam logic [7:0][4:0] BSTEP_DN = {5'd8, 5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd1, 5'd1};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [7:0] data;
  } pmoc_cmd_t;

  typedef struct packed {
    logic en;
    logic [2:0] tstep;
    logic [2:0] bstep;
  } pmoc_ramp_cfg_t;

  typedef enum logic [1:0] {
    OUT_OFF = 2'b00,
    OUT_ON_WAIT = 2'b01,
    OUT_ON = 2'b10,
    OUT_OFF_WAIT = 2'b11
  } pmoc_out_st_t;

endpackage

// ==== rtl/pmoc_wait.sv ====
// Millisecond countdown timer with its own prescaler.
// Assumes a start pulse from logic on the same clock.
`timescale 1ns/1ns
module pmoc_wait #(
  parameter int MS_CYCLES = pmoc_pkg::MS_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [11:0] i_ms,
  output logic o_busy,
  output logic o_done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [11:0] ms;
    logic [15:0] pre;
  } pmoc_wait_st_t;

  pmoc_wait_st_t st_r;
  pmoc_wait_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (i_start) begin
      // Restart reloads the prescaler so the delay is exact from the request
      st_nxt.busy = 1'b1;
      st_nxt.ms = i_ms;
      st_nxt.pre = 16'(MS_CYCLES - 1);
    end else if (st_r.busy) begin
      if (st_r.ms == 12'h000) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else if (st_r.pre == 16'h0000) begin
        st_nxt.pre = 16'(MS_CYCLES - 1);
        st_nxt.ms = st_r.ms - 12'h001;
      end else begin
        st_nxt.pre = st_r.pre - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = st_r.busy;
  assign o_done = st_r.done;

endmodule // pmoc_wait

// ==== rtl/pmoc_ramp.sv ====
// Slew-limited reference stepper with fault blanking for one output.
// Assumes target and ramp settings come from logic on the same clock.
`timescale 1ns/1ns
module pmoc_ramp (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_target,
  input wire pmoc_pkg::pmoc_ramp_cfg_t i_cfg,
  output logic [6:0] o_vref,
  output logic o_blank
);

  typedef struct packed {
    logic [6:0] vref;
    logic [8:0] tmr;
    logic [11:0] blank;
  } pmoc_ramp_st_t;

  pmoc_ramp_st_t st_r;
  pmoc_ramp_st_t st_nxt;
  logic [6:0] step_up;
  logic [6:0] step_dn;
  logic [6:0] dist_up;
  logic [6:0] dist_dn;

  assign step_up = 7'(pmoc_pkg::BSTEP_UP[i_cfg.bstep]);
  assign step_dn = 7'(pmoc_pkg::BSTEP_DN[i_cfg.bstep]);
  assign dist_up = i_target - st_r.vref;
  assign dist_dn = st_r.vref - i_target;

  always_comb begin
    st_nxt = st_r;
    if (st_r.vref != i_target) begin
      st_nxt.blank = 12'(pmoc_pkg::BLANK_CYC);
      if (!i_cfg.en) begin
        st_nxt.vref = i_target;
      end else if (st_r.tmr != 9'h000) begin
        st_nxt.tmr = st_r.tmr - 9'h001;
      end else begin
        st_nxt.tmr = 9'(32'(pmoc_pkg::TSTEP_US[i_cfg.tstep]) * pmoc_pkg::US_CYC - 1);
        if (i_target > st_r.vref) begin
          st_nxt.vref = (dist_up <= step_up) ? st_r.vref + 7'h01 : st_r.vref + step_up;
        end else begin
          st_nxt.vref = (dist_dn <= step_dn) ? st_r.vref - 7'h01 : st_r.vref - step_dn;
        end
      end
    end else begin
      st_nxt.tmr = 9'h000;
      if (st_r.blank != 12'h000) begin
        st_nxt.blank = st_r.blank - 12'h001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.vref <= pmoc_pkg::REF_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_vref = st_r.vref;
  assign o_blank = (st_r.vref != i_target) || (st_r.blank != 12'h000);

endmodule // pmoc_ramp

// ==== rtl/pmoc_output_config.sv ====
// Paged and global output configuration commands with turn-on and turn-off timing.
// Assumes a command decoder that presents one byte command per strobe and
// the current page; chip enable and supply-good arrive from pins.
//
// Behaviour
// - Setpoint: 7 bits, 10 mV steps, default 0x14
// - Setpoint changes while running ramp toward target
// - Faults blanked during ramp plus 100 us
// - Outputs 0-1: 3-bit current limit, default 100
// - Outputs 2-3: 2-bit current limit, default 11
// - One code sets both switch limits
// - Paged commands act on selected page 0-3
// - Notify flag cleared by reset, host sets
// - Software reset acts like reset pin pulse
// - Notify, software reset, hold time are global
// - No start before hold delay; requests held
// - Hold code selects 1 to 2000 ms
// - Hold counted after supply settles, exact timing
// - On wait bits 5:3, off wait 2:0
// - Zero wait code acts immediately
// - Waits skipped by immediate off and faults
// - Frequency and phase writes have no effect
// - Step size per timestep, single step near end
`timescale 1ns/1ns
module pmoc_output_config #(
  parameter int MS_CYCLES = pmoc_pkg::MS_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire pmoc_pkg::pmoc_cmd_t i_cmd,
  input wire logic [7:0] i_page,
  input wire logic i_chip_en,
  input wire logic i_supply_ok,
  input wire logic [3:0] i_on_req,
  input wire logic [3:0] i_off_req,
  input wire logic [3:0] i_off_now,
  input wire logic [3:0] i_fault_off,
  input wire pmoc_pkg::pmoc_ramp_cfg_t [3:0] i_ramp_cfg,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [3:0] o_out_en,
  output logic [3:0][6:0] o_vref,
  output logic [3:0] o_fault_blank,
  output logic [3:0][2:0] o_ilim,
  output logic o_sw_reset_pulse,
  output logic o_hold_done
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ce_sync;
    logic [1:0] ok_sync;
    logic armed;
    logic hold_done;
    logic [3:0][6:0] ref_sp;
    logic [3:0][2:0] ilim;
    logic [3:0][5:0] waits;
    logic [2:0] hold;
    logic notify;
    pmoc_pkg::pmoc_out_st_t [3:0] ost;
    logic [3:0] pend;
    logic srst;
    logic [7:0] rd_data;
    logic rd_valid;
  } pmoc_top_st_t;

  pmoc_top_st_t st_r;
  pmoc_top_st_t st_nxt;
  logic rst_int_n;
  logic page_ok;
  logic [1:0] pg;
  logic ce_ok;
  logic h_start;
  logic h_done;
  logic [3:0] w_start;
  logic [3:0][11:0] w_ms;
  logic [3:0] w_done;

  // Software reset drives the same synchronous reset as the pin
  assign rst_int_n = i_rst_n & ~st_r.srst;
  assign page_ok = (i_page <= pmoc_pkg::PAGE_MAX);
  assign pg = i_page[1:0];
  assign ce_ok = st_r.ce_sync[1] & st_r.ok_sync[1];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    h_start = 1'b0;
    w_start = '0;
    w_ms = '0;

    // Pin synchronisers
    st_nxt.ce_sync = {st_r.ce_sync[0], i_chip_en};
    st_nxt.ok_sync = {st_r.ok_sync[0], i_supply_ok};

    // Start-up hold: begins once enable is seen and the core supply is good
    if (!ce_ok) begin
      st_nxt.armed = 1'b0;
      st_nxt.hold_done = 1'b0;
    end else begin
      if (!st_r.armed) begin
        st_nxt.armed = 1'b1;
        h_start = 1'b1;
      end
      if (h_done && st_r.armed) begin
        st_nxt.hold_done = 1'b1;
      end
    end

    // Command writes
    if (i_cmd.wr) begin
      unique case (i_cmd.code)
        pmoc_pkg::CMD_REF_SETPOINT: begin
          if (page_ok) begin
            st_nxt.ref_sp[pg] = i_cmd.data[pmoc_pkg::REF_MSB:0];
          end
        end
        pmoc_pkg::CMD_CUR_LIMIT: begin
          if (page_ok) begin
            if (pg[1]) begin
              st_nxt.ilim[pg] = {1'b0, i_cmd.data[pmoc_pkg::ILIM_NARROW_MSB:0]};
            end else begin
              st_nxt.ilim[pg] = i_cmd.data[pmoc_pkg::ILIM_WIDE_MSB:0];
            end
          end
        end
        pmoc_pkg::CMD_NOTIFY_FLAG: begin
          st_nxt.notify = i_cmd.data[pmoc_pkg::NOTIFY_BIT];
        end
        pmoc_pkg::CMD_SW_RST: begin
          st_nxt.srst = 1'b1;
        end
        pmoc_pkg::CMD_HOLD_TIME: begin
          st_nxt.hold = i_cmd.data[2:0];
        end
        pmoc_pkg::CMD_WAIT_TIMES: begin
          if (page_ok) begin
            st_nxt.waits[pg] = i_cmd.data[5:0];
          end
        end
        // Frequency and phase are only loaded from storage at reset
        pmoc_pkg::CMD_FREQ_PHASE: begin
        end
        default: begin
        end
      endcase
    end

    // Command reads
    st_nxt.rd_valid = i_cmd.rd;
    if (i_cmd.rd) begin
      unique case (i_cmd.code)
        pmoc_pkg::CMD_REF_SETPOINT: begin
          st_nxt.rd_data = page_ok ? {1'b0, st_r.ref_sp[pg]} : 8'h00;
        end
        pmoc_pkg::CMD_CUR_LIMIT: begin
          st_nxt.rd_data = page_ok ? {5'h00, st_r.ilim[pg]} : 8'h00;
        end
        pmoc_pkg::CMD_NOTIFY_FLAG: begin
          st_nxt.rd_data = {7'h00, st_r.notify};
        end
        pmoc_pkg::CMD_HOLD_TIME: begin
          st_nxt.rd_data = {5'h00, st_r.hold};
        end
        pmoc_pkg::CMD_WAIT_TIMES: begin
          st_nxt.rd_data = page_ok ? {2'h0, st_r.waits[pg]} : 8'h00;
        end
        default: begin
          st_nxt.rd_data = 8'h00;
        end
      endcase
    end

    // Per-output turn-on and turn-off sequencing
    for (int i = 0; i < pmoc_pkg::NUM_OUT; i++) begin
      unique case (st_r.ost[i])
        pmoc_pkg::OUT_OFF: begin
          if (i_off_req[i]) begin
            st_nxt.pend[i] = 1'b0;
          end else if (i_on_req[i] || st_r.pend[i]) begin
            if (st_r.hold_done) begin
              w_start[i] = 1'b1;
              w_ms[i] = pmoc_pkg::WAIT_MS[st_r.waits[i][pmoc_pkg::ON_WAIT_LSB +: 3]];
              st_nxt.pend[i] = 1'b0;
              st_nxt.ost[i] = pmoc_pkg::OUT_ON_WAIT;
            end else begin
              st_nxt.pend[i] = 1'b1;
            end
          end
        end
        pmoc_pkg::OUT_ON_WAIT: begin
          if (i_off_req[i]) begin
            st_nxt.ost[i] = pmoc_pkg::OUT_OFF;
          end else if (i_on_req[i]) begin
            w_start[i] = 1'b1;
            w_ms[i] = pmoc_pkg::WAIT_MS[st_r.waits[i][pmoc_pkg::ON_WAIT_LSB +: 3]];
          end else if (w_done[i]) begin
            st_nxt.ost[i] = pmoc_pkg::OUT_ON;
          end
        end
        pmoc_pkg::OUT_ON: begin
          if (i_off_req[i]) begin
            w_start[i] = 1'b1;
            w_ms[i] = pmoc_pkg::WAIT_MS[st_r.waits[i][pmoc_pkg::OFF_WAIT_LSB +: 3]];
            st_nxt.ost[i] = pmoc_pkg::OUT_OFF_WAIT;
          end
        end
        pmoc_pkg::OUT_OFF_WAIT: begin
          if (i_on_req[i]) begin
            w_start[i] = 1'b1;
            w_ms[i] = pmoc_pkg::WAIT_MS[st_r.waits[i][pmoc_pkg::ON_WAIT_LSB +: 3]];
            st_nxt.ost[i] = pmoc_pkg::OUT_ON_WAIT;
          end else if (w_done[i]) begin
            st_nxt.ost[i] = pmoc_pkg::OUT_OFF;
          end
        end
      endcase
      // Immediate off and internal shutdown bypass the waits
      if (i_off_now[i] || i_fault_off[i]) begin
        st_nxt.ost[i] = pmoc_pkg::OUT_OFF;
        st_nxt.pend[i] = 1'b0;
      end else if (!ce_ok) begin
        st_nxt.ost[i] = pmoc_pkg::OUT_OFF;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!rst_int_n) begin
      st_r <= '0;
      st_r.ref_sp <= {4{pmoc_pkg::REF_RST}};
      st_r.ilim <= {pmoc_pkg::ILIM_NARROW_RST, pmoc_pkg::ILIM_NARROW_RST,
                    pmoc_pkg::ILIM_WIDE_RST, pmoc_pkg::ILIM_WIDE_RST};
      st_r.waits <= {4{pmoc_pkg::WAITS_RST}};
      st_r.hold <= pmoc_pkg::HOLD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Timers and ramps
  // ----------------------------------------------------------------------
  pmoc_wait #(
    .MS_CYCLES(MS_CYCLES)
  ) u_hold (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_int_n),
    .i_start(h_start),
    .i_ms(pmoc_pkg::HOLD_MS[st_r.hold]),
    .o_busy(),
    .o_done(h_done)
  );

  for (genvar g = 0; g < pmoc_pkg::NUM_OUT; g++) begin : g_out
    pmoc_wait #(
      .MS_CYCLES(MS_CYCLES)
    ) u_wait (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_int_n),
      .i_start(w_start[g]),
      .i_ms(w_ms[g]),
      .o_busy(),
      .o_done(w_done[g])
    );

    pmoc_ramp u_ramp (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_int_n),
      .i_target(st_r.ref_sp[g]),
      .i_cfg(i_ramp_cfg[g]),
      .o_vref(o_vref[g]),
      .o_blank(o_fault_blank[g])
    );

    assign o_out_en[g] = (st_r.ost[g] == pmoc_pkg::OUT_ON) ||
                         (st_r.ost[g] == pmoc_pkg::OUT_OFF_WAIT);
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_ilim = st_r.ilim;
  assign o_rd_data = st_r.rd_data;
  assign o_rd_valid = st_r.rd_valid;
  assign o_sw_reset_pulse = st_r.srst;
  assign o_hold_done = st_r.hold_done;

endmodule // pmoc_output_config

// ==== verification/pmoc_output_config_assertions.sv ====
// Port-level assertions for the output configuration command bank.
// Assumes binding into pmoc_output_config; one clock domain.
`timescale 1ns/1ns
module pmoc_output_config_assertions #(
  parameter int MS_CYCLES = pmoc_pkg::MS_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire pmoc_pkg::pmoc_cmd_t i_cmd,
  input wire logic i_chip_en,
  input wire logic [3:0] i_off_now,
  input wire logic [3:0] i_fault_off,
  input wire logic o_rd_valid,
  input wire logic [3:0] o_out_en,
  input wire logic [3:0][6:0] o_vref,
  input wire logic [3:0] o_fault_blank,
  input wire logic [3:0][2:0] o_ilim,
  input wire logic o_sw_reset_pulse,
  input wire logic o_hold_done
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------------
  // Software reset steps
  // ----------------------------------------------------------------------
  sequence s_srst_req;
    i_cmd.wr && i_cmd.code == pmoc_pkg::CMD_SW_RST && !o_sw_reset_pulse;
  endsequence
  sequence s_srst_done;
    o_sw_reset_pulse ##1 (!o_sw_reset_pulse && o_out_en == 4'h0 && !o_hold_done
      && o_vref[0] == 7'h14);
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  AST_SRST_SEQ: assert property (s_srst_req |-> ##1 s_srst_done)
    else $error("software reset did not act as a reset pulse");
  AST_RD_ANSWER: assert property (i_cmd.rd && !o_sw_reset_pulse |=> o_rd_valid)
    else $error("read not answered after one cycle");
  AST_RD_CAUSE: assert property (o_rd_valid |-> $past(i_cmd.rd))
    else $error("read valid without a read request");
  AST_ILIM_NARROW: assert property (o_ilim[2][2] == 1'b0 && o_ilim[3][2] == 1'b0)
    else $error("narrow current limit has bit 2 set");
  AST_FORCED_OFF: assert property ((|(i_off_now | i_fault_off))
    |=> (o_out_en & $past(i_off_now | i_fault_off)) == 4'h0)
    else $error("output still enabled after forced off");
  AST_EN_AFTER_HOLD: assert property ((o_out_en & ~$past(o_out_en)) != 4'h0
    |-> o_hold_done)
    else $error("output started before hold expired");
  AST_CE_LOW_STOPS: assert property (!i_chip_en [*6] |-> !o_hold_done && o_out_en == 4'h0)
    else $error("hold or outputs active with chip enable low");
  AST_BLANK_ON_MOVE: assert property ($changed(o_vref[0]) && !$past(o_sw_reset_pulse)
    |-> o_fault_blank[0] [*8])
    else $error("faults not blanked around a setpoint step");
  AST_STEP_BOUND: assert property ($changed(o_vref[0]) && !$past(o_sw_reset_pulse)
    |-> ({1'b0, o_vref[0]} - {1'b0, $past(o_vref[0])}) inside
    {[8'h01:8'h10], [8'hf8:8'hff]})
    else $error("setpoint step larger than the slew limit");
endmodule  // pmoc_output_config_assertions

bind pmoc_output_config pmoc_output_config_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .i_chip_en(i_chip_en),
  .i_off_now(i_off_now), .i_fault_off(i_fault_off), .o_rd_valid(o_rd_valid),
  .o_out_en(o_out_en), .o_vref(o_vref), .o_fault_blank(o_fault_blank), .o_ilim(o_ilim),
  .o_sw_reset_pulse(o_sw_reset_pulse), .o_hold_done(o_hold_done)
);

// ==== verification/pmoc_host.sv ====
// Host-side command source for the output configuration bank.
// Assumes the bench calls its tasks; it drives just after rising edges.
`timescale 1ns/1ns
module pmoc_host (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  output pmoc_pkg::pmoc_cmd_t o_cmd,
  output logic [7:0] o_page
);
  initial begin
    o_cmd = '0;
    o_page = 8'h00;
  end

  // Page goes out with each command so paged accesses never see a stale one
  task automatic put(input logic [7:0] page, input logic [7:0] code,
                     input logic [7:0] data, input logic rd);
    @(posedge i_ref_clk);
    o_page <= page;
    o_cmd <= '{wr: !rd, rd: rd, code: code, data: data};
    @(posedge i_ref_clk);
    // Released fields carry no stale value
    o_cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
  endtask

  task automatic get(input logic [7:0] page, input logic [7:0] code,
                     output logic [7:0] data);
    put(page, code, 8'h00, 1'b1);
    @(negedge i_ref_clk);
    data = i_rd_valid ? i_rd_data : 8'hxx;
  endtask
endmodule  // pmoc_host

// ==== verification/pmoc_output_config_test.sv ====
// Self-checking bench for the output configuration command bank.
// Assumes a 20 MHz clock and a shortened millisecond of 20 cycles.
`timescale 1ns/1ns
module pmoc_output_config_test;
  localparam int MSC = 20;
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] code;
    logic [7:0] data;
    logic [7:0] exp;
  } pmoc_row_t;
  // Write then read back: page, code, data written, value expected
  pmoc_row_t rows [10] = '{32'h00d8ff7f, 32'h03d81e1e, 32'h04d83300, 32'h00d9ff07,
    32'h02d9ff03, 32'h07da0101, 32'h05dcfa02, 32'h01ddff3f, 32'h00d75500, 32'h00d01200};
  // Values after reset: page, code, unused, value expected
  pmoc_row_t rst_rows [6] = '{32'h00d80014, 32'h00d90004, 32'h02d90003, 32'h00da0000,
    32'h00dc0000, 32'h01dd0010};
  logic ref_clk = 1'b0;
  logic rst_n, chip_en, supply_ok;
  logic [3:0] on_req, off_req, off_now, fault_off;
  pmoc_pkg::pmoc_ramp_cfg_t [3:0] ramp_cfg;
  pmoc_pkg::pmoc_cmd_t cmd;
  logic [7:0] page, rd_data, rd;
  logic rd_valid, srst_pulse, hold_done;
  logic [3:0] out_en, blank;
  logic [3:0][6:0] vref;
  logic [3:0][2:0] ilim;
  int n_fail = 0;
  int cmp_count = 0;
  int n;

  always #25 ref_clk = ~ref_clk;

  pmoc_host u_pmoc_host (.i_ref_clk(ref_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_cmd(cmd), .o_page(page));
  pmoc_output_config #(.MS_CYCLES(MSC)) u_pmoc_output_config (.i_ref_clk(ref_clk),
    .i_rst_n(rst_n), .i_cmd(cmd), .i_page(page), .i_chip_en(chip_en),
    .i_supply_ok(supply_ok), .i_on_req(on_req), .i_off_req(off_req), .i_off_now(off_now),
    .i_fault_off(fault_off), .i_ramp_cfg(ramp_cfg), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_out_en(out_en), .o_vref(vref), .o_fault_blank(blank),
    .o_ilim(ilim), .o_sw_reset_pulse(srst_pulse), .o_hold_done(hold_done));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Request pulse on output 1: bits are fault, off now, off, on
  task automatic req(input logic [3:0] kind);
    @(posedge ref_clk);
    {fault_off[1], off_now[1], off_req[1], on_req[1]} <= kind;
    @(posedge ref_clk);
    {fault_off[1], off_now[1], off_req[1], on_req[1]} <= 4'h0;
  endtask

  task automatic wait_en(input logic v, input int lim);
    int k;
    k = 0;
    while (out_en[1] !== v && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    check({7'h0, out_en[1]}, {7'h0, v});
  endtask

  initial begin
    #500000;
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    chip_en = 1'b0;
    supply_ok = 1'b0;
    {on_req, off_req, off_now, fault_off} = '0;
    ramp_cfg = {4{7'h47}};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      u_pmoc_host.put(rows[i].page, rows[i].code, rows[i].data, 1'b0);
      u_pmoc_host.get(rows[i].page, rows[i].code, rd);
      check(rd, rows[i].exp);
    end
    check({5'h0, ilim[0]}, 8'h07);
    check({5'h0, ilim[2]}, 8'h03);
    check({5'h0, ilim[1]}, 8'h04);
    $display("register table test done");
    u_pmoc_host.put(8'h01, 8'hd8, 8'h35, 1'b0);
    repeat (10) @(negedge ref_clk);
    check({1'b0, vref[1]}, 8'h24);
    check({7'h0, blank[1]}, 8'h01);
    repeat (90) @(negedge ref_clk);
    check({1'b0, vref[1]}, 8'h35);
    repeat (1500) @(negedge ref_clk);
    check({7'h0, blank[1]}, 8'h01);
    repeat (700) @(negedge ref_clk);
    check({7'h0, blank[1]}, 8'h00);
    $display("setpoint ramp test done");
    u_pmoc_host.put(8'h00, 8'hdb, 8'h01, 1'b0);
    @(negedge ref_clk);
    check({7'h0, srst_pulse}, 8'h01);
    repeat (3) @(negedge ref_clk);
    check({1'b0, vref[0]}, 8'h14);
    foreach (rst_rows[i]) begin
      u_pmoc_host.get(rst_rows[i].page, rst_rows[i].code, rd);
      check(rd, rst_rows[i].exp);
    end
    $display("software reset test done");
    u_pmoc_host.put(8'h01, 8'hdd, 8'h00, 1'b0);
    // Hold of 50 ms, so a zero turn-on wait keeps the host recommendation
    u_pmoc_host.put(8'h00, 8'hdc, 8'h01, 1'b0);
    req(4'h1);
    repeat (40) @(negedge ref_clk);
    check({7'h0, out_en[1]}, 8'h00);
    @(posedge ref_clk);
    chip_en <= 1'b1;
    supply_ok <= 1'b1;
    n = 0;
    while (hold_done !== 1'b1 && n < 1100) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h0, (n >= 50 * MSC && n <= 50 * MSC + 8)}, 8'h01);
    wait_en(1'b1, 6);
    req(4'h2);
    wait_en(1'b0, 5);
    u_pmoc_host.put(8'h01, 8'hdd, 8'h08, 1'b0);
    req(4'h1);
    repeat (15) @(negedge ref_clk);
    check({7'h0, out_en[1]}, 8'h00);
    req(4'h1);
    repeat (15) @(negedge ref_clk);
    check({7'h0, out_en[1]}, 8'h00);
    wait_en(1'b1, 12);
    req(4'h4);
    wait_en(1'b0, 1);
    req(4'h1);
    wait_en(1'b1, 30);
    req(4'h8);
    wait_en(1'b0, 1);
    @(posedge ref_clk);
    chip_en <= 1'b0;
    repeat (8) @(negedge ref_clk);
    check({7'h0, hold_done}, 8'h00);
    $display("turn on and off test done");
    finish_test();
  end
endmodule  // pmoc_output_config_test
